// ---- verilog/cgs_pkg.sv ----
// Constants and carrier types for the clock generator status and
// first output driver control register group.
// Assumes a serial control port front end on the same clock that
// presents a decoded byte address with a write strobe.
//
// Function
// - Status bit 3 shows clock above threshold
// - Status bit 2 shows reference two above threshold
// - Status bit 1 shows reference one above threshold
// - Status bit 0 shows digital lock detect
// - Control bit 7 picks LVDS or CMOS
// - CMOS field acts only in CMOS format
// - Field 6:5 enables none, A, B, both
package cgs_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W         = 10;
	localparam int          DATA_W         = 8;
	localparam logic [9:0]  STATUS_ADDR    = 10'h01F;
	localparam logic [9:0]  OUT_CTRL_ADDR  = 10'h0F0;
	localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          ST_CLK_BIT     = 3;
	localparam int          ST_REFERENCE_INPUT_TWO_BIT    = 2;
	localparam int          ST_REFERENCE_INPUT_ONE_BIT    = 1;
	localparam int          ST_LOCK_BIT    = 0;
	localparam int          FMT_BIT        = 7;
	localparam int          CMOS_HI_BIT    = 6;
	localparam int          CMOS_LO_BIT    = 5;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [7:0]  OUT_CTRL_RST   = 8'h62;
	localparam logic [7:0]  STATUS_PAD     = 8'h00;
	localparam logic        FMT_LVDS       = 1'h0;
	localparam logic        FMT_CMOS       = 1'h1;
	localparam logic [1:0]  CMOS_NONE      = 2'h0;
	localparam logic [1:0]  CMOS_A_ONLY    = 2'h1;
	localparam logic [1:0]  CMOS_B_ONLY    = 2'h2;
	localparam logic [1:0]  CMOS_BOTH      = 2'h3;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	// Live monitor and lock flags, packed in readback order
	typedef struct packed {
		logic clk_above;
		logic reference_input_two_above;
		logic reference_input_one_above;
		logic locked;
	} cgs_status_t;

	// Driver steering for the first output channel
	typedef struct packed {
		logic cmos_sel;
		logic lvds_en;
		logic half_a_en;
		logic half_b_en;
	} cgs_drive_t;

endpackage : cgs_pkg

// ---- verilog/cgs_regs.sv ----
// Status readback and first output channel control registers.
// Assumes monitor and lock inputs come from other clock domains and
// the register port and threshold select run on clock_in.
`timescale 1ns/1ns
`default_nettype none

module cgs_regs (
	// Clock and reset
	input  wire logic                    clock_in,
	input  wire logic                    rst_n_in,
	// Register port
	input  wire logic [9:0]              reg_addr_in,
	input  wire logic                    reg_wr_in,
	input  wire logic [7:0]              reg_wdata_in,
	output logic      [7:0]              reg_rdata_out,
	// Monitor inputs, asynchronous
	input  wire logic                    clk_above_in,
	input  wire logic                    reference_input_one_above_lo_in,
	input  wire logic                    reference_input_one_above_hi_in,
	input  wire logic                    reference_input_two_above_lo_in,
	input  wire logic                    reference_input_two_above_hi_in,
	input  wire logic                    pll_locked_in,
	// Threshold select from configuration, same clock
	input  wire logic                    ref_thresh_hi_in,
	// Driver steering
	output var cgs_pkg::cgs_drive_t      drive_out,
	output logic      [7:0]              out_ctrl_out
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [5:0] raw_in;
	logic [5:0] sync1_ff;
	logic [5:0] sync2_ff;
	logic [5:0] nxt_sync1;
	logic [5:0] nxt_sync2;

	assign raw_in = {clk_above_in, reference_input_two_above_hi_in, reference_input_two_above_lo_in,
	                 reference_input_one_above_hi_in, reference_input_one_above_lo_in, pll_locked_in};

	// First stage feeds only the second stage
	always_comb begin
		nxt_sync1 = rst_n_in ? raw_in : 6'h00;
		nxt_sync2 = rst_n_in ? sync1_ff : 6'h00;
	end

	always_ff @(posedge clock_in) begin
		sync1_ff <= nxt_sync1;
		sync2_ff <= nxt_sync2;
	end

	// ----------------------------------------------------------------
	// Live status
	// ----------------------------------------------------------------
	cgs_pkg::cgs_status_t status;
	logic [7:0]           status_byte;

	// Threshold select chooses which comparator result is shown
	always_comb begin
		status.clk_above  = sync2_ff[5];
		status.reference_input_two_above = ref_thresh_hi_in ? sync2_ff[4] : sync2_ff[3];
		status.reference_input_one_above = ref_thresh_hi_in ? sync2_ff[2] : sync2_ff[1];
		status.locked     = sync2_ff[0];
		status_byte       = cgs_pkg::STATUS_PAD | {4'h0, status};
	end

	// Readback trails the second synchroniser stage by one edge; the
	// threshold select is taken on the same edge as the address
	clk_flag_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		reg_addr_in == cgs_pkg::STATUS_ADDR |=> reg_rdata_out[3] == $past(sync2_ff[5]))
		else $error("clock flag readback wrong");

	reference_input_two_flag_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		reg_addr_in == cgs_pkg::STATUS_ADDR |=> reg_rdata_out[2] ==
		($past(ref_thresh_hi_in) ? $past(sync2_ff[4]) : $past(sync2_ff[3])))
		else $error("reference two flag readback wrong");

	reference_input_one_flag_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		reg_addr_in == cgs_pkg::STATUS_ADDR |=> reg_rdata_out[1] ==
		($past(ref_thresh_hi_in) ? $past(sync2_ff[2]) : $past(sync2_ff[1])))
		else $error("reference one flag readback wrong");

	// Lock rising at the pin reaches readback three edges later, the cost
	// of the two-stage synchroniser plus the registered read port
	lock_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(pll_locked_in) ##0 (pll_locked_in && reg_addr_in == cgs_pkg::STATUS_ADDR) [*3]
		|=> reg_rdata_out[0])
		else $error("lock flag not seen three edges after rise");

	// ----------------------------------------------------------------
	// Control register and readback
	// ----------------------------------------------------------------
	logic [7:0] ctrl_ff;
	logic [7:0] nxt_ctrl;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	// Only the control address is writable
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (reg_wr_in && reg_addr_in == cgs_pkg::OUT_CTRL_ADDR) begin
			nxt_ctrl = reg_wdata_in;
		end
		if (!rst_n_in) begin
			nxt_ctrl = cgs_pkg::OUT_CTRL_RST;
		end
	end

	// Read data is sampled fresh each cycle, so status trails the pins by only three edges
	always_comb begin
		case (reg_addr_in)
			cgs_pkg::STATUS_ADDR:   nxt_rdata = status_byte;
			cgs_pkg::OUT_CTRL_ADDR: nxt_rdata = ctrl_ff;
			default:                nxt_rdata = cgs_pkg::UNMAPPED_DATA;
		endcase
		if (!rst_n_in) begin
			nxt_rdata = 8'h00;
		end
	end

	always_ff @(posedge clock_in) begin
		ctrl_ff  <= nxt_ctrl;
		rdata_ff <= nxt_rdata;
	end

	assign reg_rdata_out = rdata_ff;
	assign out_ctrl_out  = ctrl_ff;

	// Register port checks: only a control write moves the control byte,
	// and readback shows the byte addressed on the previous edge
	status_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		reg_wr_in && reg_addr_in == cgs_pkg::STATUS_ADDR |=> $stable(out_ctrl_out))
		else $error("status write changed control");

	ctrl_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!(reg_wr_in && reg_addr_in == cgs_pkg::OUT_CTRL_ADDR) |=> $stable(out_ctrl_out))
		else $error("control changed without a write");

	status_pad_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		reg_addr_in == cgs_pkg::STATUS_ADDR |=> reg_rdata_out[7:4] == 4'h0)
		else $error("status upper bits not zero");

	ctrl_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		reg_addr_in == cgs_pkg::OUT_CTRL_ADDR |=> reg_rdata_out == $past(out_ctrl_out))
		else $error("control readback wrong");

	// ----------------------------------------------------------------
	// Driver decode
	// ----------------------------------------------------------------
	cgs_pkg::cgs_drive_t drive_ff;
	cgs_pkg::cgs_drive_t nxt_drive;
	logic [1:0]          cmos_cfg;

	// Decoding the next control value keeps steering in step with the
	// control byte while it still leaves from a flip-flop, glitch free
	assign cmos_cfg = nxt_ctrl[cgs_pkg::CMOS_HI_BIT:cgs_pkg::CMOS_LO_BIT];

	// Halves stay off in LVDS mode whatever the field holds
	always_comb begin
		nxt_drive.cmos_sel  = nxt_ctrl[cgs_pkg::FMT_BIT];
		nxt_drive.lvds_en   = nxt_ctrl[cgs_pkg::FMT_BIT] == cgs_pkg::FMT_LVDS;
		nxt_drive.half_a_en = 1'b0;
		nxt_drive.half_b_en = 1'b0;
		if (nxt_ctrl[cgs_pkg::FMT_BIT] == cgs_pkg::FMT_CMOS) begin
			case (cmos_cfg)
				cgs_pkg::CMOS_NONE:   nxt_drive.half_a_en = 1'b0;
				cgs_pkg::CMOS_A_ONLY: nxt_drive.half_a_en = 1'b1;
				cgs_pkg::CMOS_B_ONLY: nxt_drive.half_b_en = 1'b1;
				cgs_pkg::CMOS_BOTH: begin
					nxt_drive.half_a_en = 1'b1;
					nxt_drive.half_b_en = 1'b1;
				end
				default:              nxt_drive.half_a_en = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		drive_ff <= nxt_drive;
	end

	assign drive_out = drive_ff;

	// Steering checks: reset format, format bit, LVDS gating and the
	// half decode as seen one edge after the write
	format_sel_a: assert property (@(posedge clock_in)
		!rst_n_in |=> !drive_out.cmos_sel && drive_out.lvds_en)
		else $error("format not LVDS after reset");

	cmos_format_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		out_ctrl_out[7] |-> drive_out.cmos_sel && !drive_out.lvds_en)
		else $error("format not CMOS with format bit set");

	lvds_halves_off_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		drive_out.lvds_en |-> !drive_out.half_a_en && !drive_out.half_b_en)
		else $error("CMOS half driven in LVDS mode");

	cmos_field_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		out_ctrl_out[7] |-> drive_out.half_a_en == out_ctrl_out[5]
		&& drive_out.half_b_en == out_ctrl_out[6])
		else $error("CMOS field not applied in CMOS format");

	half_decode_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		reg_wr_in && reg_addr_in == cgs_pkg::OUT_CTRL_ADDR && reg_wdata_in[7]
		|=> drive_out.half_a_en == $past(reg_wdata_in[5])
		&& drive_out.half_b_en == $past(reg_wdata_in[6]))
		else $error("half enable decode wrong");

endmodule : cgs_regs

`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the status readback and first output control.
// Assumes cgs_regs alone on one clock, its ports driven straight from here.
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic                clock_in    = 1'h0;
	logic                rst_n_in    = 1'h0;
	logic [9:0]          addr        = 10'h000;
	logic                wr          = 1'h0;
	logic [7:0]          wdata       = 8'h00;
	logic [6:0]          mon         = 7'h00;
	logic [7:0]          rdata;
	logic [7:0]          ctrl;
	cgs_pkg::cgs_drive_t drv;
	int                  n_errors    = 0;
	int                  comparisons = 0;
	// Rows: wdata, monitors {clk,r2hi,r2lo,r1hi,r1lo,lock,thr_hi}, drive, status
	logic [22:0]         rows [5]    = '{
		{8'hE0, 7'h6B, 4'hB, 4'hF},
		{8'hA0, 7'h15, 4'hA, 4'h0},
		{8'hC0, 7'h58, 4'h9, 4'hC},
		{8'h80, 7'h26, 4'h8, 4'h3},
		{8'h7F, 7'h03, 4'h4, 4'h1}};

	cgs_regs cgs_regs_inst (
		.clock_in         (clock_in),
		.rst_n_in         (rst_n_in),
		.reg_addr_in      (addr),
		.reg_wr_in        (wr),
		.reg_wdata_in     (wdata),
		.reg_rdata_out    (rdata),
		.clk_above_in     (mon[6]),
		.reference_input_two_above_hi_in (mon[5]),
		.reference_input_two_above_lo_in (mon[4]),
		.reference_input_one_above_hi_in (mon[3]),
		.reference_input_one_above_lo_in (mon[2]),
		.pll_locked_in    (mon[1]),
		.ref_thresh_hi_in (mon[0]),
		.drive_out        (drv),
		.out_ctrl_out     (ctrl)
	);

	// 25 MHz clock
	always #20 clock_in = ~clock_in;

	// Compare and count, report at once
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// One write pulse, held across one sampling edge
	task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
		@(posedge clock_in);
		#1;
		addr  = a;
		wr    = 1'h1;
		wdata = d;
		@(posedge clock_in);
		#1;
		wr    = 1'h0;
	endtask : wr_reg

	// Read data is registered, so look one edge after the address
	task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
		@(posedge clock_in);
		#1;
		addr = a;
		@(posedge clock_in);
		#1;
		d = rdata;
	endtask : rd_reg

	task automatic end_sim;
		if (n_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	// Watchdog, far beyond the sixty or so cycles the tests need
	initial begin
		#80000;
		n_errors++;
		end_sim;
	end

	// Main sequence: table rows first, then the awkward cases
	initial begin
		logic [7:0] rv;
		repeat (4) @(posedge clock_in);
		#1;
		chk("ctrl reset", ctrl, 8'h62);
		chk("drive reset", {4'h0, drv}, 8'h04);
		rst_n_in = 1'h1;
		foreach (rows[i]) begin
			mon = rows[i][14:8];
			wr_reg(cgs_pkg::OUT_CTRL_ADDR, rows[i][22:15]);
			chk("ctrl", ctrl, rows[i][22:15]);
			chk("drive", {4'h0, drv}, {4'h0, rows[i][7:4]});
			rd_reg(cgs_pkg::OUT_CTRL_ADDR, rv);
			chk("ctrl read", rv, rows[i][22:15]);
			rd_reg(cgs_pkg::STATUS_ADDR, rv);
			chk("status", rv, {4'h0, rows[i][3:0]});
		end
		// Writes to status or unmapped places leave control alone
		wr_reg(cgs_pkg::STATUS_ADDR, 8'hFF);
		chk("ctrl kept", ctrl, 8'h7F);
		wr_reg(10'h0F1, 8'h80);
		chk("ctrl kept", ctrl, 8'h7F);
		rd_reg(10'h0F1, rv);
		chk("unmapped", rv, 8'h00);
		// Status follows the monitors, not a stored copy
		mon = 7'h7E;
		repeat (3) @(posedge clock_in);
		rd_reg(cgs_pkg::STATUS_ADDR, rv);
		chk("status live", rv, 8'h0F);
		mon = 7'h01;
		repeat (3) @(posedge clock_in);
		rd_reg(cgs_pkg::STATUS_ADDR, rv);
		chk("status live", rv, 8'h00);
		// Lock rising while the status address is held
		mon = 7'h03;
		repeat (3) @(posedge clock_in);
		rd_reg(cgs_pkg::STATUS_ADDR, rv);
		chk("lock live", rv, 8'h01);
		// Mid-run reset brings back the defaults
		rst_n_in = 1'h0;
		repeat (4) @(posedge clock_in);
		#1;
		chk("ctrl reset", ctrl, 8'h62);
		chk("drive reset", {4'h0, drv}, 8'h04);
		chk("rdata reset", rdata, 8'h00);
		rst_n_in = 1'h1;
		// First write straight after release must land
		wr_reg(cgs_pkg::OUT_CTRL_ADDR, 8'hA0);
		chk("ctrl after reset", ctrl, 8'hA0);
		chk("drive after reset", {4'h0, drv}, 8'h0A);
		end_sim;
	end
endmodule : tb

`default_nettype wire
